// File: hdl/tile_lock_defs.vh
// Constants for the tile protection word, register map and OTP geometry
`ifndef TILE_LOCK_DEFS_VH
`define TILE_LOCK_DEFS_VH

// Protection word bit positions
`define PW_DBG_OFF 0
`define PW_LINK_OFF 1
`define PW_SEC_BOOT 5
`define PW_REDUND 7
`define PW_SECT_LO 8
`define PW_SECT_HI 11
`define PW_MASTER 12
`define PW_DBG_OTP_OFF 13
`define PW_PIN_OFF 14
`define PW_USER_LO 15
`define PW_USER_HI 21
`define PW_ID_LO 22
`define PW_ID_HI 31

// OTP geometry
`define OTP_SECTORS 4
`define OTP_ROWS 512
`define OTP_ROW_W 11
`define OTP_WORD_W 32
`define OTP_PROT_ROW 11'h7ff

// Register byte offsets
`define OFS_PROT 8'h00
`define OFS_STAT 8'h04

// Status register fields
`define ST_LOADED 0
`define ST_DBG_DENY 1
`define ST_OTP_DENY 2
`define ST_LINK_DENY 3
`define ST_PROG_DENY 4

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: hdl/otp_word_loader.v
// Power-up fetch of the protection word from OTP
`timescale 1ns/1ps
`include "tile_lock_defs.vh"
module otp_word_loader #(
  parameter [10:0] PROT_ROW = `OTP_PROT_ROW
) (
  input wire aclk,
  input wire aresetn,
  output reg otp_rd_en,
  output reg [10:0] otp_rd_row,
  input wire otp_rd_valid,
  input wire [31:0] otp_rd_data,
  output reg loaded,
  output reg load_pulse,
  output reg [31:0] word
);
  localparam [1:0] ST_START = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;
  reg [1:0] state_q;

  // Read one row once after reset, then hold the word until the next reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_START;
      otp_rd_en <= 1'b0;
      otp_rd_row <= 11'h000;
      loaded <= 1'b0;
      load_pulse <= 1'b0;
      word <= 32'h0000_0000;
    end else begin
      load_pulse <= 1'b0;
      case (state_q)
        ST_START: begin
          otp_rd_en <= 1'b1;
          otp_rd_row <= PROT_ROW;
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (otp_rd_valid) begin
            otp_rd_en <= 1'b0;
            word <= otp_rd_data;
            loaded <= 1'b1;
            load_pulse <= 1'b1;
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_DONE;
        end
        default: begin
          state_q <= ST_START;
        end
      endcase
    end
  end
endmodule

// File: hdl/otp_prog_gate.v
// Grants or refuses OTP programming requests against the sector and master locks
`timescale 1ns/1ps
`include "tile_lock_defs.vh"
module otp_prog_gate (
  input wire aclk,
  input wire aresetn,
  input wire loaded,
  input wire [4:0] locks,
  input wire prog_valid,
  input wire prog_to_prot,
  input wire [10:0] prog_row,
  output reg prog_grant,
  output reg prog_deny
);
  // Sector n covers rows n*512 .. n*512+511
  function sector_locked;
    input [3:0] sect_locks;
    input [10:0] row;
    begin
      sector_locked = sect_locks[row[10:9]];
    end
  endfunction

  wire refuse;
  assign refuse = !loaded || locks[4] || (!prog_to_prot && sector_locked(locks[3:0], prog_row));

  // One-cycle answer after each request
  always @(posedge aclk) begin
    if (!aresetn) begin
      prog_grant <= 1'b0;
      prog_deny <= 1'b0;
    end else begin
      prog_grant <= prog_valid && !refuse;
      prog_deny <= prog_valid && refuse;
    end
  end
endmodule

// File: hdl/tile_security_lock_control.v
// Tile security lock control: protection word, access gating and register slave
`timescale 1ns/1ps
`include "tile_lock_defs.vh"
module tile_security_lock_control #(
  parameter ADDR_W = 8,
  parameter [10:0] PROT_ROW = `OTP_PROT_ROW
) (
  input wire aclk,
  input wire aresetn,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire otp_rd_en,
  output wire [10:0] otp_rd_row,
  input wire otp_rd_valid,
  input wire [31:0] otp_rd_data,
  input wire dbg_req_valid,
  input wire dbg_req_otp,
  input wire dbg_req_write,
  output reg dbg_grant,
  output reg dbg_deny,
  input wire link_req_valid,
  output reg link_grant,
  output reg link_deny,
  input wire prog_valid,
  input wire prog_to_prot,
  input wire [10:0] prog_row,
  output wire prog_grant,
  output wire prog_deny,
  input wire debug_req_n,
  output reg debug_halt,
  output reg boot_release,
  output reg boot_from_otp,
  output reg otp_redundant_en,
  output reg [9:0] usercode_id,
  output wire protection_loaded
);
  // Loaded word, effective word and sticky flag state
  wire load_pulse;
  wire [31:0] otp_word;
  reg [6:0] user_q;
  reg [6:0] user_d;
  reg [3:0] sticky_q;
  reg [3:0] sticky_d;
  wire [31:0] prot_word;
  wire [31:0] status_word;
  // Write and read channel holding registers
  reg aw_held_q;
  reg [ADDR_W-1:0] aw_addr_q;
  reg w_held_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire wr_fire;
  wire [ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire wr_prot_hit;
  wire wr_stat_hit;
  wire dbg_refuse;
  wire link_refuse;
  reg [ADDR_W-1:0] ar_addr_q;
  reg dbg_req_otp_q;

  // Register decode: the word index of a byte address against a byte offset,
  // so that the low address bits never take part in the match
  function reg_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      reg_hit = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  // Power-up fetch of the protection word
  otp_word_loader #(
    .PROT_ROW(PROT_ROW)
  ) u_loader (
    .aclk(aclk),
    .aresetn(aresetn),
    .otp_rd_en(otp_rd_en),
    .otp_rd_row(otp_rd_row),
    .otp_rd_valid(otp_rd_valid),
    .otp_rd_data(otp_rd_data),
    .loaded(protection_loaded),
    .load_pulse(load_pulse),
    .word(otp_word)
  );

  // Programming lock checks
  otp_prog_gate u_prog_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .loaded(protection_loaded),
    .locks(otp_word[`PW_MASTER:`PW_SECT_LO]),
    .prog_valid(prog_valid),
    .prog_to_prot(prog_to_prot),
    .prog_row(prog_row),
    .prog_grant(prog_grant),
    .prog_deny(prog_deny)
  );

  // Effective word: only the general purpose field can change after loading
  assign prot_word = {otp_word[`PW_ID_HI:`PW_ID_LO], user_q,
                      otp_word[`PW_USER_LO-1:0]};
  // Status: loaded flag under the four sticky refusal flags
  assign status_word = {27'h0, sticky_q, protection_loaded};

  // Access refusal terms, everything refused until the word is loaded;
  // bit 0 refuses OTP requests as well, bit 13 refuses only those
  assign dbg_refuse = !protection_loaded || otp_word[`PW_DBG_OFF] ||
                      (dbg_req_otp && otp_word[`PW_DBG_OTP_OFF]);
  assign link_refuse = !protection_loaded || otp_word[`PW_LINK_OFF];

  // Debug port and link answers, one cycle after the request
  always @(posedge aclk) begin
    if (!aresetn) begin
      dbg_grant <= 1'b0;
      dbg_deny <= 1'b0;
      link_grant <= 1'b0;
      link_deny <= 1'b0;
    end else begin
      dbg_grant <= dbg_req_valid && !dbg_refuse;
      dbg_deny <= dbg_req_valid && dbg_refuse;
      link_grant <= link_req_valid && !link_refuse;
      link_deny <= link_req_valid && link_refuse;
    end
  end

  // Static controls driven from the loaded word
  always @(posedge aclk) begin
    if (!aresetn) begin
      debug_halt <= 1'b0;
      boot_release <= 1'b0;
      boot_from_otp <= 1'b0;
      otp_redundant_en <= 1'b0;
      usercode_id <= 10'h000;
    end else begin
      debug_halt <= protection_loaded && !otp_word[`PW_PIN_OFF] && !debug_req_n;
      boot_release <= protection_loaded;
      boot_from_otp <= protection_loaded && otp_word[`PW_SEC_BOOT];
      otp_redundant_en <= protection_loaded && otp_word[`PW_REDUND];
      usercode_id <= protection_loaded ? otp_word[`PW_ID_HI:`PW_ID_LO] : 10'h000;
    end
  end

  // Write address and data are accepted independently and held until paired;
  // the response is raised only once both handshakes have completed
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_addr = aw_addr_q;
  assign wr_data = w_data_q;
  assign wr_strb = w_strb_q;
  assign wr_prot_hit = wr_fire && reg_hit(wr_addr[7:0], `OFS_PROT);
  assign wr_stat_hit = wr_fire && reg_hit(wr_addr[7:0], `OFS_STAT);

  // Answer each paired write once, then release both holding registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= {ADDR_W{1'b0}};
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !aw_held_q && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_prot_hit || wr_stat_hit) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
    end
  end

  // General purpose field: seeded by the load, then software may rewrite it
  always @* begin
    user_d = user_q;
    if (load_pulse) begin
      user_d = otp_word[`PW_USER_HI:`PW_USER_LO];
    end else if (wr_prot_hit && protection_loaded) begin
      if (wr_strb[1]) begin
        user_d[0] = wr_data[15];
      end
      if (wr_strb[2]) begin
        user_d[6:1] = wr_data[21:16];
      end
    end
  end

  // Sticky refusal flags: write one to clear, a new refusal wins over the clear;
  // each flag is set the cycle after its deny pulse
  always @* begin
    sticky_d = sticky_q;
    if (wr_stat_hit && wr_strb[0]) begin
      sticky_d = sticky_q & ~wr_data[`ST_PROG_DENY:`ST_DBG_DENY];
    end
    if (dbg_deny && !dbg_req_otp_q) begin
      sticky_d[0] = 1'b1;
    end
    if (dbg_deny && dbg_req_otp_q) begin
      sticky_d[1] = 1'b1;
    end
    if (link_deny) begin
      sticky_d[2] = 1'b1;
    end
    if (prog_deny) begin
      sticky_d[3] = 1'b1;
    end
  end

  // Field, flag and request-target registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      user_q <= 7'h00;
      sticky_q <= 4'h0;
      dbg_req_otp_q <= 1'b0;
    end else begin
      user_q <= user_d;
      sticky_q <= sticky_d;
      dbg_req_otp_q <= dbg_req_otp;
    end
  end

  // Read channel: the address is taken first and the data follows the edge at
  // which that handshake completes, so rvalid never rises ahead of it
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      ar_addr_q <= {ADDR_W{1'b0}};
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        ar_addr_q <= s_axi_araddr;
      end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        if (reg_hit(ar_addr_q[7:0], `OFS_PROT)) begin
          s_axi_rdata <= prot_word;
          s_axi_rresp <= `RESP_OKAY;
        end else if (reg_hit(ar_addr_q[7:0], `OFS_STAT)) begin
          s_axi_rdata <= status_word;
          s_axi_rresp <= `RESP_OKAY;
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: verif/otp_model.sv
// Behavioural OTP that answers the power-up fetch of the protection word
`timescale 1ns/1ps
module otp_model (
  input wire aclk,
  input wire aresetn,
  input wire otp_rd_en,
  input wire [10:0] otp_rd_row,
  input wire [31:0] word,
  input wire [3:0] lat,
  output reg otp_rd_valid,
  output reg [31:0] otp_rd_data
);
  reg [3:0] cnt_q;
  initial {otp_rd_valid, otp_rd_data, cnt_q} = 0;
  // Answers lat cycles late; between answers the data bus keeps toggling
  always @(posedge aclk) begin
    otp_rd_valid <= 1'b0;
    otp_rd_data <= ~otp_rd_data;
    cnt_q <= 4'h0;
    if (aresetn && otp_rd_en && !otp_rd_valid) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == lat) begin
        otp_rd_valid <= 1'b1;
        otp_rd_data <= (otp_rd_row == 11'h7ff) ? word : ~word;
      end
    end
  end
endmodule

// File: verif/lock_props.sv
// Checker of the lock controller answers and derived outputs
`timescale 1ns/1ps
module lock_props #(
  parameter [10:0] PROT_ROW = 11'h7ff
) (
  input wire aclk,
  input wire aresetn,
  input wire otp_rd_en,
  input wire [10:0] otp_rd_row,
  input wire otp_rd_valid,
  input wire [31:0] otp_rd_data,
  input wire dbg_req_valid,
  input wire dbg_req_otp,
  input wire dbg_grant,
  input wire dbg_deny,
  input wire link_req_valid,
  input wire link_grant,
  input wire link_deny,
  input wire prog_valid,
  input wire prog_to_prot,
  input wire [10:0] prog_row,
  input wire prog_grant,
  input wire prog_deny,
  input wire debug_req_n,
  input wire debug_halt,
  input wire boot_from_otp,
  input wire otp_redundant_en,
  input wire [9:0] usercode_id,
  input wire protection_loaded
);
  reg [31:0] w_q;
  wire ld = protection_loaded;
  wire db = !ld || w_q[0] || (dbg_req_otp && w_q[13]);
  wire lb = !ld || w_q[1];
  wire pb = !ld || w_q[12] || (!prog_to_prot && w_q[8 + prog_row[10:9]]);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Copy of the word as the OTP hands it over
  always @(posedge aclk) if (otp_rd_en && otp_rd_valid) w_q <= otp_rd_data;
  AST_DBG: assert property (dbg_req_valid |=>
    dbg_deny == $past(db) && dbg_grant != $past(db)) else $error("debug answer");
  AST_LINK: assert property (link_req_valid |=>
    link_deny == $past(lb) && link_grant != $past(lb)) else $error("link answer");
  AST_PROG: assert property (prog_valid |=>
    prog_deny == $past(pb) && prog_grant != $past(pb)) else $error("program answer");
  AST_QUIET: assert property (!dbg_req_valid && !link_req_valid && !prog_valid |=>
    !(dbg_grant || dbg_deny || link_grant || link_deny || prog_grant || prog_deny))
    else $error("answer without request");
  AST_BOOT: assert property (ld |=>
    boot_from_otp == w_q[5] && otp_redundant_en == w_q[7]) else $error("boot mode");
  AST_UID: assert property (usercode_id == (ld && $past(ld) ? w_q[31:22] : 10'h0))
    else $error("user id");
  AST_HALT: assert property (ld |=> debug_halt == $past(!w_q[14] && !debug_req_n))
    else $error("debug pin");
  AST_FETCH: assert property ($rose(ld) |-> $past(otp_rd_en && otp_rd_valid))
    else $error("load without fetch");
  AST_ROW: assert property (otp_rd_en |-> otp_rd_row == PROT_ROW)
    else $error("fetch row");
endmodule
bind tile_security_lock_control lock_props #(.PROT_ROW(PROT_ROW)) lock_props_inst (
  .aclk, .aresetn, .otp_rd_en, .otp_rd_row, .otp_rd_valid, .otp_rd_data, .dbg_req_valid,
  .dbg_req_otp, .dbg_grant, .dbg_deny, .link_req_valid, .link_grant, .link_deny, .prog_valid,
  .prog_to_prot, .prog_row, .prog_grant, .prog_deny, .debug_req_n, .debug_halt, .boot_from_otp,
  .otp_redundant_en, .usercode_id, .protection_loaded
);

// File: verif/test_tile_security_lock_control.sv
// Self-checking bench of the tile lock controller
`timescale 1ns/1ps
module test_tile_security_lock_control;
  reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg dbg_req_valid, dbg_req_otp, dbg_req_write, link_req_valid, prog_valid, prog_to_prot;
  reg debug_req_n;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata, w, d;
  reg [3:0] s_axi_wstrb, lat, sk;
  reg [2:0] s_axi_awprot, s_axi_arprot;
  reg [10:0] prog_row;
  reg [5:0] r;
  reg [5:0] notes[$];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, otp_rd_en;
  wire otp_rd_valid, dbg_grant, dbg_deny, link_grant, link_deny, prog_grant, prog_deny;
  wire debug_halt, boot_release, boot_from_otp, otp_redundant_en, protection_loaded;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, otp_rd_data;
  wire [10:0] otp_rd_row;
  wire [9:0] usercode_id;
  integer seed, n_mismatch, n_checks, k, i;
  tile_security_lock_control tile_security_lock_control_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .otp_rd_en, .otp_rd_row, .otp_rd_valid, .otp_rd_data,
    .dbg_req_valid, .dbg_req_otp, .dbg_req_write, .dbg_grant, .dbg_deny, .link_req_valid,
    .link_grant, .link_deny, .prog_valid, .prog_to_prot, .prog_row, .prog_grant, .prog_deny,
    .debug_req_n, .debug_halt, .boot_release, .boot_from_otp, .otp_redundant_en, .usercode_id,
    .protection_loaded
  );
  otp_model otp_model_inst (
    .aclk, .aresetn, .otp_rd_en, .otp_rd_row, .otp_rd_valid, .otp_rd_data, .word(w), .lat
  );
  // Free running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task give_verdict;
    begin
      if (n_mismatch == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: got %h, expected %h", $time, g, e);
      end
    end
  endtask
  task tmo;
    begin
      chk(32'h1, 32'h0);
      give_verdict;
    end
  endtask
  // One register access; bready or rready stays up until the answer is sampled
  task axi(input wn, input [7:0] a, input [31:0] dv, input [3:0] s, input [31:0] e,
    input [1:0] er);
    integer j;
    begin
      @(posedge aclk);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= {a, a, dv, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wn}};
      {s_axi_arvalid, s_axi_rready} <= {2{!wn}};
      for (j = 0; j < 50; j = j + 1) begin
        @(posedge aclk);
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1 || s_axi_rvalid === 1'b1) begin
          chk(wn ? s_axi_bresp : s_axi_rresp, er);
          if (!wn) chk(s_axi_rdata, e);
          {s_axi_bready, s_axi_rready} <= 2'b00;
          j = 99;
        end
      end
      if (j == 50) tmo;
    end
  endtask
  // Random requests on all three ports; the expected answer goes into the queue
  task req(input ld, input en);
    reg [31:0] v;
    reg db, lb, pb;
    begin
      @(posedge aclk);
      v = en ? $random(seed) : 0;
      {prog_row, debug_req_n, prog_to_prot, prog_valid, link_req_valid, dbg_req_write,
        dbg_req_otp, dbg_req_valid} <= v[17:0];
      db = !ld || w[0] || (v[1] && w[13]);
      lb = !ld || w[1];
      pb = !ld || w[12] || (!v[5] && w[8 + v[17:16]]);
      if (v[0] && db) sk[v[1]] = 1'b1;
      if (v[3] && lb) sk[2] = 1'b1;
      if (v[4] && pb) sk[3] = 1'b1;
      if (v[0] || v[3] || v[4]) begin
        notes.push_back({v[0] && !db, v[0] && db, v[3] && !lb, v[3] && lb, v[4] && !pb,
          v[4] && pb});
      end
    end
  endtask
  // Matches each answer pulse against the oldest note
  always @(negedge aclk) begin
    r = {dbg_grant, dbg_deny, link_grant, link_deny, prog_grant, prog_deny};
    if (aresetn && r !== 6'h0) chk(r, notes.size() ? notes.pop_front() : 6'h0);
  end
  // Reloads a new word each round, then requests and register traffic
  initial begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awprot, s_axi_arprot,
      s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, dbg_req_valid,
      dbg_req_otp, dbg_req_write, link_req_valid, prog_valid, prog_to_prot, debug_req_n,
      prog_row, w, d, lat} = 0;
    seed = 95848;
    n_mismatch = 0;
    n_checks = 0;
    for (k = 0; k < 6; k = k + 1) begin
      w = (k == 0) ? 32'h0 : (k == 1) ? 32'hffffffff : $random(seed);
      lat = 6 + k;
      sk = 4'h0;
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) req(0, 1);
      chk(usercode_id, 0);
      req(0, 0);
      for (i = 0; i < 60 && protection_loaded !== 1'b1; i = i + 1) @(posedge aclk);
      if (i == 60) tmo;
      @(posedge aclk);
      chk(boot_from_otp, w[5]);
      chk(otp_redundant_en, w[7]);
      chk(usercode_id, w[31:22]);
      chk(boot_release, 1);
      repeat (40) req(1, 1);
      req(1, 0);
      repeat (3) @(posedge aclk);
      axi(0, 8'h04, 0, 0, {27'h0, sk, 1'b1}, 2'h0);
      axi(1, 8'h04, 32'h1e, 4'h1, 0, 2'h0);
      axi(0, 8'h04, 0, 0, 32'h1, 2'h0);
      d = $random(seed);
      axi(1, 8'h00, d, 4'hf, 0, 2'h0);
      w = (w & ~32'h003f8000) | (d & 32'h003f8000);
      axi(0, 8'h00, 0, 0, w, 2'h0);
      axi(1, 8'h08, d, 4'hf, 0, 2'h2);
      axi(0, 8'h08, 0, 0, 0, 2'h2);
    end
    chk(notes.size(), 0);
    give_verdict;
  end
endmodule
